// >>> verilog/odtc_regs.svh
`ifndef ODTC_REGS_SVH
`define ODTC_REGS_SVH

// command codes, upper nibble of the instruction word
`define ODTC_CMD_WRITE_N 4'h0
`define ODTC_CMD_UPDATE_N 4'h1
`define ODTC_CMD_WRITE_UPD_N 4'h3
`define ODTC_CMD_PD_N 4'h4
`define ODTC_CMD_PD_CHIP 4'h5
`define ODTC_CMD_SPAN_N 4'h6
`define ODTC_CMD_UPDATE_ALL 4'h9
`define ODTC_CMD_TOGGLE_SEL 4'hC
`define ODTC_CMD_GLOBAL_TGB 4'hD
`define ODTC_CMD_SPAN_ALL 4'hE
`define ODTC_CMD_NOP 4'hF

// instruction word layout
`define ODTC_WORD_W 32
`define ODTC_CMD_MSB 31
`define ODTC_CMD_LSB 28
`define ODTC_ADDR_MSB 27
`define ODTC_ADDR_LSB 24
`define ODTC_DATA_MSB 23
`define ODTC_DATA_LSB 8
`define ODTC_TSR_MSB 7
`define ODTC_TGB_BIT 0
`define ODTC_SPAN_MSB 2
`define ODTC_NUM_CH 8

// reset values
`define ODTC_TSR_RESET 8'h00
`define ODTC_TGB_RESET 1'b0
`define ODTC_SYNC_RESET 5'h0C

// synchronised pin positions
`define ODTC_PIN_SCK 0
`define ODTC_PIN_SDI 1
`define ODTC_PIN_CS 2
`define ODTC_PIN_ASYNC_LOAD_PIN 3
`define ODTC_PIN_TGP 4
`define ODTC_PIN_W 5

// timing
`define ODTC_CLK_PERIOD_NS 25
`define ODTC_PU_CHAN_NS 30000
`define ODTC_PU_CHIP_NS 35000
`define ODTC_PU_CHAN_CYC ((`ODTC_PU_CHAN_NS + `ODTC_CLK_PERIOD_NS - 1) / `ODTC_CLK_PERIOD_NS)
`define ODTC_PU_CHIP_CYC ((`ODTC_PU_CHIP_NS + `ODTC_CLK_PERIOD_NS - 1) / `ODTC_CLK_PERIOD_NS)
`define ODTC_PU_CNT_W 11

`endif

// >>> verilog/odtc_pkg.sv
`default_nettype none
`include "odtc_regs.svh"

package odtc_pkg;

    typedef enum logic [3:0] {
        CMD_WRITE_N = `ODTC_CMD_WRITE_N,
        CMD_UPDATE_N = `ODTC_CMD_UPDATE_N,
        CMD_WRITE_UPD_N = `ODTC_CMD_WRITE_UPD_N,
        CMD_PD_N = `ODTC_CMD_PD_N,
        CMD_PD_CHIP = `ODTC_CMD_PD_CHIP,
        CMD_SPAN_N = `ODTC_CMD_SPAN_N,
        CMD_UPDATE_ALL = `ODTC_CMD_UPDATE_ALL,
        CMD_TOGGLE_SEL = `ODTC_CMD_TOGGLE_SEL,
        CMD_GLOBAL_TGB = `ODTC_CMD_GLOBAL_TGB,
        CMD_SPAN_ALL = `ODTC_CMD_SPAN_ALL,
        CMD_NOP = `ODTC_CMD_NOP
    } odtc_cmd_t;

    typedef logic [`ODTC_NUM_CH-1:0][15:0] odtc_code_arr_t;
    typedef logic [`ODTC_NUM_CH-1:0][`ODTC_SPAN_MSB:0] odtc_span_arr_t;

    typedef struct packed {
        logic [`ODTC_PIN_W-1:0] meta;
        logic [`ODTC_PIN_W-1:0] stable;
    } odtc_sync_state_t;

    typedef struct packed {
        logic [`ODTC_WORD_W-1:0] shift;
        logic sdo;
        logic [`ODTC_PIN_W-1:0] prev;
        logic [`ODTC_NUM_CH-1:0] toggle_channel_select;
        logic global_toggle_bit;
        odtc_code_arr_t inA;
        odtc_code_arr_t inB;
        odtc_code_arr_t dac;
        odtc_span_arr_t spanIn;
        odtc_span_arr_t spanDac;
        logic [`ODTC_NUM_CH-1:0] chanDown;
        logic chipDown;
        logic [`ODTC_PU_CNT_W-1:0] puCount;
    } odtc_state_t;

endpackage

`default_nettype wire

// >>> verilog/odtc_sync.sv
`timescale 1ns/100ps
`default_nettype none
`include "odtc_regs.svh"

module odtc_sync (
    input wire logic clk,
    input wire logic reset,
    input wire logic [`ODTC_PIN_W-1:0] rawIn,
    output logic [`ODTC_PIN_W-1:0] syncOut
);
    import odtc_pkg::*;

    odtc_sync_state_t state_ff;
    odtc_sync_state_t nxt_state;

    // first stage feeds only the second stage
    always_comb begin
        nxt_state.meta = rawIn;
        nxt_state.stable = state_ff.meta;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_ff <= '{meta: `ODTC_SYNC_RESET, stable: `ODTC_SYNC_RESET};
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign syncOut = state_ff.stable;

endmodule

`default_nettype wire

// >>> verilog/odtc_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
`include "odtc_regs.svh"

// What this block does
// - command 1100b loads toggle select bits, data bit x selects channel x.
// - code write goes to register B if channel's select bit set, else A.
// - only channels with select bit set follow global toggle events.
// - toggles are edge triggered; steady levels cause no update.
// - command 1101b writes global toggle bit; falling edge loads A into selected DACs.
// - global toggle bit rising loads B into selected DACs while the toggle pin is high, A while it is low.
// - toggle pin falling edge loads A, rising edge loads B if global toggle bit set (else A), selected channels.
// - update-all or async load picks B where select bit, global toggle bit and toggle pin are all high, else A.
// - serial input reappears at serial output after 32 rising clocks, on falling edge.
// - serial output echoes the previous 32-bit instruction during each frame.
// - serial output released while chip-select/load is high.
// - command in shift register executes on chip-select/load rising edge.
// - command 1111 does nothing.
// - command 0100b powers down the addressed channel.
// - command 0101b powers down all channels and the reference.
// - power-down commands ignore the data field.
// - power-down leaves input, DAC and select registers intact.
// - any update powers the updated channel back up.
// - power-up takes 30 us from channel, 35 us from chip power-down.
// - select bits clear after reset.
// - update copies input code and span into the DAC register.
// - async load low with chip-select/load high updates all channels.
module odtc_ctrl (
    input wire logic clk,
    input wire logic reset,
    input wire logic sck,
    input wire logic sdi,
    input wire logic chipSelectLoad,
    input wire logic asyncLoadPin_n,
    input wire logic externalTogglePin,
    output logic sdoOut,
    output logic sdoOe,
    output odtc_pkg::odtc_code_arr_t dacCode,
    output odtc_pkg::odtc_span_arr_t dacSpan,
    output logic [`ODTC_NUM_CH-1:0] channelPowered,
    output logic referencePowered,
    output logic powerUpBusy
);
    import odtc_pkg::*;

    localparam int PU_CHAN_CYC = `ODTC_PU_CHAN_CYC;
    localparam int PU_CHIP_CYC = `ODTC_PU_CHIP_CYC;
    localparam odtc_state_t STATE_RESET = '{
        shift: '0,
        sdo: 1'b0,
        prev: `ODTC_SYNC_RESET,
        toggle_channel_select: `ODTC_TSR_RESET,
        global_toggle_bit: `ODTC_TGB_RESET,
        inA: '0,
        inB: '0,
        dac: '0,
        spanIn: '0,
        spanDac: '0,
        chanDown: '0,
        chipDown: 1'b0,
        puCount: '0
    };

    odtc_state_t state_ff;
    odtc_state_t nxt_state;
    logic [`ODTC_PIN_W-1:0] syn;
    logic sckRise;
    logic sckFall;
    logic csLow;
    logic csRise;
    logic csFall;
    logic ldacLow;
    logic ldacUpd;
    logic tgpHigh;
    logic tgpEdge;
    odtc_cmd_t cmd;
    logic [3:0] addr;
    logic [15:0] data;
    logic chanOk;
    logic [2:0] ch;
    logic [`ODTC_NUM_CH-1:0] nxtTsr;
    logic nxtTgb;
    logic tgbEvent;
    logic [`ODTC_NUM_CH-1:0] useB;
    logic [`ODTC_NUM_CH-1:0] cmdMask;
    logic [`ODTC_NUM_CH-1:0] updMask;
    logic wakeFromDown;

    // every pin crosses two flops before any logic sees it
    odtc_sync u_sync (
        .clk(clk),
        .reset(reset),
        .rawIn({externalTogglePin, asyncLoadPin_n, chipSelectLoad, sdi, sck}),
        .syncOut(syn)
    );

    assign sckRise = syn[`ODTC_PIN_SCK] & ~state_ff.prev[`ODTC_PIN_SCK];
    assign sckFall = ~syn[`ODTC_PIN_SCK] & state_ff.prev[`ODTC_PIN_SCK];
    assign csLow = ~syn[`ODTC_PIN_CS];
    assign csRise = syn[`ODTC_PIN_CS] & ~state_ff.prev[`ODTC_PIN_CS];
    assign csFall = ~syn[`ODTC_PIN_CS] & state_ff.prev[`ODTC_PIN_CS];
    assign ldacLow = ~syn[`ODTC_PIN_ASYNC_LOAD_PIN];
    assign ldacUpd = ldacLow & ~csLow;
    assign tgpHigh = syn[`ODTC_PIN_TGP];
    // pin resets low; a high idle pin gives one edge after reset, harmless while select bits are clear
    assign tgpEdge = syn[`ODTC_PIN_TGP] ^ state_ff.prev[`ODTC_PIN_TGP];

    // field split of the captured word
    assign cmd = odtc_cmd_t'(state_ff.shift[`ODTC_CMD_MSB:`ODTC_CMD_LSB]);
    assign addr = state_ff.shift[`ODTC_ADDR_MSB:`ODTC_ADDR_LSB];
    assign data = state_ff.shift[`ODTC_DATA_MSB:`ODTC_DATA_LSB];
    assign chanOk = addr < 4'(`ODTC_NUM_CH);
    assign ch = addr[2:0];

    assign nxtTsr = (csRise && cmd == CMD_TOGGLE_SEL) ? data[`ODTC_TSR_MSB:0] : state_ff.toggle_channel_select;
    assign nxtTgb = (csRise && cmd == CMD_GLOBAL_TGB) ? data[`ODTC_TGB_BIT] : state_ff.global_toggle_bit;
    assign tgbEvent = nxtTgb != state_ff.global_toggle_bit;

    // a channel reads B only when select, global bit and pin all agree
    assign useB = nxtTsr & {`ODTC_NUM_CH{nxtTgb & tgpHigh}};

    always_comb begin
        cmdMask = '0;
        if (csRise && chanOk && (cmd == CMD_UPDATE_N || cmd == CMD_WRITE_UPD_N)) begin
            cmdMask[ch] = 1'b1;
        end
        if (csRise && cmd == CMD_UPDATE_ALL) begin
            cmdMask = '1;
        end
    end

    // toggle events touch selected channels only
    assign updMask = cmdMask | {`ODTC_NUM_CH{ldacUpd}} | ((tgbEvent | tgpEdge) ? nxtTsr : '0);
    assign wakeFromDown = |(updMask & state_ff.chanDown);

    always_comb begin
        nxt_state = state_ff;
        nxt_state.prev = syn;
        if (csLow && sckRise) begin
            nxt_state.shift = {state_ff.shift[`ODTC_WORD_W-2:0], syn[`ODTC_PIN_SDI]};
        end
        // the old word is still whole at frame start, so it is echoed first
        if (csFall || (csLow && sckFall)) begin
            nxt_state.sdo = state_ff.shift[`ODTC_WORD_W-1];
        end
        nxt_state.toggle_channel_select = nxtTsr;
        nxt_state.global_toggle_bit = nxtTgb;
        if (csRise) begin
            case (cmd)
                CMD_WRITE_N, CMD_WRITE_UPD_N: begin
                    if (chanOk && state_ff.toggle_channel_select[ch]) begin
                        nxt_state.inB[ch] = data;
                    end else if (chanOk) begin
                        nxt_state.inA[ch] = data;
                    end
                end
                CMD_SPAN_N: begin
                    if (chanOk) begin
                        nxt_state.spanIn[ch] = data[`ODTC_SPAN_MSB:0];
                    end
                end
                CMD_SPAN_ALL: begin
                    nxt_state.spanIn = {`ODTC_NUM_CH{data[`ODTC_SPAN_MSB:0]}};
                end
                CMD_PD_N: begin
                    // data ignored; async load held low inhibits power-down
                    if (chanOk && !ldacLow) begin
                        nxt_state.chanDown[ch] = 1'b1;
                    end
                end
                CMD_PD_CHIP: begin
                    if (!ldacLow) begin
                        nxt_state.chanDown = '1;
                        nxt_state.chipDown = 1'b1;
                    end
                end
                CMD_NOP: begin
                end
                default: begin
                end
            endcase
        end
        // async load low wakes outputs whatever the chip select does
        if (ldacLow) begin
            nxt_state.chanDown = '0;
            nxt_state.chipDown = 1'b0;
        end
        for (int i = 0; i < `ODTC_NUM_CH; i++) begin
            if (updMask[i]) begin
                nxt_state.dac[i] = useB[i] ? nxt_state.inB[i] : nxt_state.inA[i];
                nxt_state.spanDac[i] = nxt_state.spanIn[i];
                nxt_state.chanDown[i] = 1'b0;
            end
        end
        if (|updMask) begin
            nxt_state.chipDown = 1'b0;
        end
        // one shared settle timer; the longer chip figure wins when the chip was down
        if (wakeFromDown) begin
            nxt_state.puCount = state_ff.chipDown ? `ODTC_PU_CNT_W'(PU_CHIP_CYC) : `ODTC_PU_CNT_W'(PU_CHAN_CYC);
        end else if (state_ff.puCount != '0) begin
            nxt_state.puCount = state_ff.puCount - `ODTC_PU_CNT_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_ff <= STATE_RESET;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign sdoOut = state_ff.sdo;
    assign sdoOe = csLow;
    assign dacCode = state_ff.dac;
    assign dacSpan = state_ff.spanDac;
    assign channelPowered = ~state_ff.chanDown;
    assign referencePowered = ~state_ff.chipDown;
    assign powerUpBusy = state_ff.puCount != '0;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    a_tsr_load: assert property (csRise && cmd == CMD_TOGGLE_SEL |=> state_ff.toggle_channel_select == $past(nxtTsr))
        else $error("toggle select not loaded");
    a_write_dest: assert property (csRise && cmd == CMD_WRITE_N && chanOk && state_ff.toggle_channel_select[ch]
        |=> state_ff.inB[$past(ch)] == $past(data) && state_ff.inA == $past(state_ff.inA))
        else $error("write with select set missed register B");
    a_unsel_steady: assert property (tgpEdge && !csRise && !ldacUpd |-> updMask == state_ff.toggle_channel_select)
        else $error("pin toggle touched unselected channel");
    a_level_quiet: assert property (!csRise && !tgpEdge && !ldacUpd |-> updMask == '0)
        else $error("update without an edge");
    a_tgb_fall: assert property (csRise && cmd == CMD_GLOBAL_TGB && state_ff.global_toggle_bit && !data[`ODTC_TGB_BIT]
        && state_ff.toggle_channel_select[3] |=> state_ff.dac[3] == $past(state_ff.inA[3]))
        else $error("global toggle fall did not load A");
    a_tgb_rise: assert property (csRise && cmd == CMD_GLOBAL_TGB && !state_ff.global_toggle_bit && data[`ODTC_TGB_BIT]
        && state_ff.toggle_channel_select[3] && tgpHigh |=> state_ff.dac[3] == $past(state_ff.inB[3]))
        else $error("global toggle rise did not load B");
    a_pin_toggle: assert property (tgpEdge && !csRise && state_ff.global_toggle_bit && state_ff.toggle_channel_select[3]
        |=> state_ff.dac[3] == ($past(tgpHigh) ? $past(state_ff.inB[3]) : $past(state_ff.inA[3])))
        else $error("pin toggle picked wrong register");
    a_update_mix: assert property (csRise && cmd == CMD_UPDATE_ALL && state_ff.global_toggle_bit && tgpHigh
        |=> state_ff.dac[3] == ($past(state_ff.toggle_channel_select[3]) ? $past(state_ff.inB[3]) : $past(state_ff.inA[3])))
        else $error("update all picked wrong register");
    a_echo_out: assert property (csFall ##1 (!csFall)[*2] |-> sdoOut == $past(state_ff.shift[31], 3))
        else $error("echo bit not the old word msb");
    a_sdo_release: assert property (csRise |-> !sdoOe ##1 !sdoOe)
        else $error("serial output driven with select high");
    a_nop_idle: assert property (csRise && cmd == CMD_NOP && !ldacUpd && !tgpEdge
        |=> state_ff.dac == $past(state_ff.dac) && state_ff.chanDown == $past(state_ff.chanDown))
        else $error("no-op changed state");
    a_pd_hold: assert property (csRise && cmd == CMD_PD_N && chanOk && !ldacLow && !tgpEdge
        |=> state_ff.chanDown[$past(ch)] && state_ff.dac == $past(state_ff.dac)
        && state_ff.toggle_channel_select == $past(state_ff.toggle_channel_select))
        else $error("channel power-down wrong");
    a_chip_down: assert property (csRise && cmd == CMD_PD_CHIP && !ldacLow && !tgpEdge
        |=> state_ff.chipDown && state_ff.chanDown == '1)
        else $error("chip power-down wrong");
    a_update_wake: assert property (|updMask |=> (state_ff.chanDown & $past(updMask)) == '0 && !state_ff.chipDown)
        else $error("updated channel still down");
    a_pu_delay: assert property (wakeFromDown && !state_ff.chipDown |=> state_ff.puCount == PU_CHAN_CYC)
        else $error("channel power-up time wrong");
    a_async_load_pin_all: assert property (ldacUpd |-> updMask == '1)
        else $error("async load did not update all");
    a_span_copy: assert property (csRise && cmd == CMD_UPDATE_ALL
        |=> state_ff.spanDac == $past(state_ff.spanIn))
        else $error("update did not copy span");
    a_chip_delay: assert property (wakeFromDown && state_ff.chipDown |=> state_ff.puCount == PU_CHIP_CYC)
        else $error("chip power-up time wrong");
    a_pu_count: assert property (state_ff.puCount != '0 && !wakeFromDown
        |=> state_ff.puCount == $past(state_ff.puCount) - 1)
        else $error("settle counter did not count down");
    a_async_load_pin_wake: assert property (ldacLow |=> state_ff.chanDown == '0 && !state_ff.chipDown)
        else $error("async load did not wake outputs");
    a_shift_in: assert property (csLow && sckRise |=> state_ff.shift[0] == $past(syn[`ODTC_PIN_SDI]))
        else $error("serial input bit not shifted in");
    a_echo_shift: assert property (csLow && sckFall |=> sdoOut == $past(state_ff.shift[31]))
        else $error("serial output missed shift register msb");
    a_sck_ignored: assert property (!csLow |=> state_ff.shift == $past(state_ff.shift))
        else $error("shift register moved with select high");
    a_tsr_hold: assert property (!(csRise && cmd == CMD_TOGGLE_SEL) |=> state_ff.toggle_channel_select == $past(state_ff.toggle_channel_select))
        else $error("select bits changed without command");
    a_tgb_hold: assert property (!(csRise && cmd == CMD_GLOBAL_TGB) |=> state_ff.global_toggle_bit == $past(state_ff.global_toggle_bit))
        else $error("global toggle bit changed without command");
    a_addr_ignore: assert property (csRise && cmd == CMD_WRITE_N && !chanOk
        |=> state_ff.inA == $past(state_ff.inA) && state_ff.inB == $past(state_ff.inB))
        else $error("write to absent channel changed a register");

    c_pin_toggle: cover property (tgpEdge && state_ff.global_toggle_bit && |state_ff.toggle_channel_select);
    c_tgb_cmd: cover property (csRise && cmd == CMD_GLOBAL_TGB && tgbEvent);
    c_update_all: cover property (csRise && cmd == CMD_UPDATE_ALL);
    c_chip_wake: cover property (wakeFromDown && state_ff.chipDown);
    c_pd_chan: cover property (csRise && cmd == CMD_PD_N && chanOk);

endmodule

`default_nettype wire

// >>> sim/odtc_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module odtc_host_model (
    input wire logic clk,
    input wire logic sdoOut,
    input wire logic sdoOe,
    output logic sck,
    output logic sdi,
    output logic chipSelectLoad,
    output logic externalTogglePin,
    output logic echoValid,
    output logic [63:0] echoData
);
    logic sdoLine;
    logic bitSeen;
    // pull-up on the shared line: a released output reads high, never stale data
    assign sdoLine = sdoOe ? sdoOut : 1'b1;
    initial begin
        sck = 1'b0;
        sdi = 1'b0;
        chipSelectLoad = 1'b1;
        externalTogglePin = 1'b1;
        echoValid = 1'b0;
        echoData = 64'h0000_0000_0000_0000;
    end
    // serial clock runs only inside frames: 5 clk low, 3 clk high
    task automatic shiftBit(input logic b);
        sdi <= b;
        repeat (5) @(posedge clk);
        sck <= 1'b1;
        bitSeen = sdoLine;
        echoData <= {echoData[62:0], bitSeen};
        repeat (3) @(posedge clk);
        sck <= 1'b0;
    endtask
    task automatic startFrame;
        chipSelectLoad <= 1'b0;
        echoData <= 64'h0000_0000_0000_0000;
    endtask
    task automatic endFrame;
        repeat (3) @(posedge clk);
        chipSelectLoad <= 1'b1;
        sdi <= ~sdi;
        echoValid <= 1'b1;
        @(posedge clk);
        echoValid <= 1'b0;
        repeat (5) @(posedge clk);
    endtask
    task automatic frame32(input logic [31:0] w);
        startFrame();
        for (int i = 31; i >= 0; i--) shiftBit(w[i]);
        endFrame();
    endtask
    // farthest device's word goes out first
    task automatic frame64(input logic [63:0] w);
        startFrame();
        for (int i = 63; i >= 0; i--) shiftBit(w[i]);
        endFrame();
    endtask
    task automatic setPin(input logic v);
        externalTogglePin <= v;
        repeat (6) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// >>> sim/octal_dac_toggle_chain_control_bench.sv
`timescale 1ns/100ps
`default_nettype none
`include "odtc_regs.svh"
module octal_dac_toggle_chain_control_bench;
    import odtc_pkg::*;
    logic clk, reset, asyncLoadPin_n, sck, sdi, csl, pin, sdoOut, sdoOe, echoValid, probeNow;
    logic referencePowered, powerUpBusy, refRef, busyExp, global_toggle_bit;
    logic [63:0] echoData;
    odtc_code_arr_t dacCode, refA, refB, refDac;
    odtc_span_arr_t dacSpan, refSpanIn, refSpan;
    logic [7:0] channelPowered, refPow, toggle_channel_select;
    logic [31:0] lastWord, rnd;
    logic [162:0] seen;
    logic [63:0] echoQ[$];
    logic [162:0] stateQ[$];
    int numErrors, totalChecks;
    assign seen = {dacCode, dacSpan, channelPowered, referencePowered, powerUpBusy, sdoOe};
    odtc_ctrl DUT (.clk(clk), .reset(reset), .sck(sck), .sdi(sdi), .chipSelectLoad(csl),
        .asyncLoadPin_n(asyncLoadPin_n), .externalTogglePin(pin), .sdoOut(sdoOut), .sdoOe(sdoOe),
        .dacCode(dacCode), .dacSpan(dacSpan), .channelPowered(channelPowered),
        .referencePowered(referencePowered), .powerUpBusy(powerUpBusy));
    odtc_host_model host (.clk(clk), .sdoOut(sdoOut), .sdoOe(sdoOe), .sck(sck), .sdi(sdi),
        .chipSelectLoad(csl), .externalTogglePin(pin), .echoValid(echoValid), .echoData(echoData));
    always #12.5 clk = ~clk;
    function automatic logic [15:0] rnd16();
        rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
        return rnd[15:0];
    endfunction
    function automatic logic [31:0] wd(input logic [3:0] c, input logic [3:0] a, input logic [15:0] d);
        return {c, a, d, 8'h00};
    endfunction
    task automatic updCh(input int ch);
        refDac[ch] = (toggle_channel_select[ch] && global_toggle_bit && pin) ? refB[ch] : refA[ch];
        refPow[ch] = 1'b1;
        refSpan[ch] = refSpanIn[ch];
        refRef = 1'b1;
    endtask
    task automatic apply(input logic [31:0] w);
        logic [3:0] c, a;
        logic [15:0] d;
        c = w[31:28];
        a = w[27:24];
        d = w[23:8];
        case (c)
            CMD_WRITE_N, CMD_WRITE_UPD_N: if (a < 4'h8) begin
                if (toggle_channel_select[a]) refB[a] = d;
                else refA[a] = d;
                if (c == CMD_WRITE_UPD_N) updCh(a);
            end
            CMD_UPDATE_N: if (a < 4'h8) updCh(a);
            CMD_UPDATE_ALL: for (int i = 0; i < 8; i++) updCh(i);
            CMD_SPAN_N: if (a < 4'h8) refSpanIn[a] = d[2:0];
            CMD_SPAN_ALL: for (int i = 0; i < 8; i++) refSpanIn[i] = d[2:0];
            CMD_PD_N: if (a < 4'h8) refPow[a] = 1'b0;
            CMD_PD_CHIP: begin
                refPow = 8'h00;
                refRef = 1'b0;
            end
            CMD_TOGGLE_SEL: toggle_channel_select = d[7:0];
            CMD_GLOBAL_TGB: if (d[0] != global_toggle_bit) begin
                global_toggle_bit = d[0];
                for (int i = 0; i < 8; i++) if (toggle_channel_select[i]) updCh(i);
            end
            default: ;
        endcase
    endtask
    task automatic issue(input logic [31:0] w);
        apply(w);
        echoQ.push_back({32'h0000_0000, lastWord});
        lastWord = w;
        host.frame32(w);
    endtask
    task automatic daisy(input logic [31:0] far, input logic [31:0] ours);
        apply(ours);
        echoQ.push_back({lastWord, far});
        lastWord = ours;
        host.frame64({far, ours});
    endtask
    task automatic probe;
        stateQ.push_back({refDac, refSpan, refPow, refRef, busyExp, 1'b0});
        probeNow <= 1'b1;
        @(posedge clk);
        probeNow <= 1'b0;
    endtask
    task automatic pinEdge(input logic v);
        host.setPin(v);
        for (int i = 0; i < 8; i++) if (toggle_channel_select[i]) updCh(i);
        probe();
    endtask
    // the host must wait out the settle time before trusting the output
    task automatic puCheck(input int cyc);
        busyExp = 1'b1;
        probe();
        repeat (cyc - 40) @(posedge clk);
        probe();
        repeat (60) @(posedge clk);
        busyExp = 1'b0;
        probe();
    endtask
    task automatic checkWord(input string nm, input logic [63:0] exp, input logic [63:0] got);
        totalChecks++;
        if (got !== exp) begin
            numErrors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic checkState(input string nm, input logic [162:0] exp, input logic [162:0] got);
        totalChecks++;
        if (got !== exp) begin
            numErrors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic closeOut;
        $display("checks %0d errors %0d", totalChecks, numErrors);
        if (numErrors == 0 && totalChecks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        if (echoValid) checkWord("echo", echoQ.pop_front(), echoData);
        if (probeNow) checkState("state", stateQ.pop_front(), seen);
    end
    initial begin
        repeat (30000) @(posedge clk);
        numErrors++;
        closeOut();
    end
    initial begin
        clk = 1'b0;
        reset = 1'b1;
        asyncLoadPin_n = 1'b1;
        probeNow = 1'b0;
        {refA, refB, refDac, refSpanIn, refSpan, toggle_channel_select, global_toggle_bit, busyExp, lastWord} = '0;
        refPow = 8'hFF;
        refRef = 1'b1;
        rnd = 32'h0001_660A;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        repeat (6) @(posedge clk);
        probe();
        issue(wd(CMD_WRITE_N, 4'h3, rnd16()));
        issue(wd(CMD_UPDATE_N, 4'h3, rnd16()));
        issue(wd(CMD_TOGGLE_SEL, 4'h0, 16'hA508));
        issue(wd(CMD_WRITE_N, 4'h3, rnd16()));
        issue(wd(CMD_WRITE_N, 4'h5, rnd16()));
        probe();
        issue(wd(CMD_GLOBAL_TGB, 4'h0, 16'h0001));
        probe();
        issue(wd(CMD_WRITE_N, 4'h3, rnd16()));
        issue(wd(CMD_GLOBAL_TGB, 4'h0, 16'h0001));
        issue(wd(CMD_NOP, 4'h3, rnd16()));
        issue(wd(CMD_WRITE_N, 4'h8, rnd16()));
        probe();
        issue(wd(CMD_GLOBAL_TGB, 4'h0, 16'h0000));
        probe();
        issue(wd(CMD_GLOBAL_TGB, 4'h0, 16'h0001));
        for (int k = 0; k < 4; k++) pinEdge(k[0]);
        issue(wd(CMD_SPAN_ALL, 4'h0, rnd16()));
        issue(wd(CMD_SPAN_N, 4'h3, rnd16()));
        issue(wd(CMD_WRITE_N, 4'h0, rnd16()));
        issue(wd(CMD_UPDATE_ALL, 4'h0, rnd16()));
        probe();
        issue(wd(CMD_TOGGLE_SEL, 4'h0, 16'h0000));
        issue(wd(CMD_WRITE_N, 4'h6, rnd16()));
        asyncLoadPin_n <= 1'b0;
        repeat (3) @(posedge clk);
        asyncLoadPin_n <= 1'b1;
        repeat (6) @(posedge clk);
        for (int i = 0; i < 8; i++) updCh(i);
        probe();
        issue(wd(CMD_PD_N, 4'h5, rnd16()));
        probe();
        issue(wd(CMD_UPDATE_N, 4'h5, rnd16()));
        puCheck(`ODTC_PU_CHAN_CYC);
        issue(wd(CMD_PD_CHIP, 4'h0, rnd16()));
        probe();
        issue(wd(CMD_UPDATE_ALL, 4'h0, rnd16()));
        puCheck(`ODTC_PU_CHIP_CYC);
        daisy(wd(CMD_NOP, 4'h0, rnd16()), wd(CMD_WRITE_UPD_N, 4'h2, rnd16()));
        probe();
        closeOut();
    end
endmodule
`default_nettype wire
